// ===== rtl/conv_ctrl.sv
/*
 * converter control top: self-trim sequencing, out-of-range output,
 * full-scale selection by pin or register, apb register file and
 * interrupt.
 * assumes control pins synchronous to pclk and an apb master.
 */
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module conv_ctrl
   import conv_ctrl_pkg::*;
#(
   parameter int PWRUP_CYC = PWRUP_DELAY_CYC,
   parameter int TRIM_CYC = TRIM_LEN_CYC,
   parameter int IN_W = 10
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // control pins
   input wire logic full_scale_select,
   input wire logic extended_control_enable,
   input wire logic trim_request,
   input wire logic power_down_pin,
   // samples in
   input wire logic sample_valid,
   input wire logic [2*IN_W-1:0] sample_diff,
   // converter side outputs
   output logic [15:0] code_out,
   output logic out_of_range_p,
   output logic out_of_range_n,
   output logic self_trim_active,
   output logic powered_down,
   output logic [7:0] full_scale_code,
   // interrupt
   output logic irq
);

   // ********************************************************
   // helpers
   // ********************************************************
   trim_link_if trim_link ();
   range_link_if range_link ();

   // trim sequencing and request filtering
   trim_sequencer #(
      .PWRUP_CYC(PWRUP_CYC),
      .TRIM_CYC(TRIM_CYC)
   ) u_trim (
      .pclk(pclk),
      .presetn(presetn),
      .trim_request(trim_request),
      .power_down_pin(power_down_pin),
      .link(trim_link.seq)
   );

   // code clipping per bus
   range_monitor #(
      .BUSES(2),
      .IN_W(IN_W)
   ) u_range (
      .pclk(pclk),
      .presetn(presetn),
      .sample_valid(sample_valid),
      .sample_diff(sample_diff),
      .code_out(code_out),
      .link(range_link.mon)
   );

   // ********************************************************
   // declarations
   // ********************************************************
   logic [7:0] fs_adj_reg, fs_adj_next;       // software full-scale adjust
   logic [7:0] fs_reg, fs_next;               // applied full scale
   logic [EV_W-1:0] ist_reg, ist_next;        // sticky event bits
   logic [EV_W-1:0] imask_reg, imask_next;    // interrupt enables
   logic oor_reg, oor_next;                   // registered range flag
   logic oor_q_reg, oor_q_next;               // for rising-edge event
   logic [31:0] rdata_reg, rdata_next;        // read data
   logic err_reg, err_next;                   // slave error for this access
   logic [EV_W-1:0] ev_set;                   // event pulses this cycle
   logic wr_en;
   logic setup;
   logic mapped;
   logic [31:0] status_word;

   // ********************************************************
   // apb decode
   // ********************************************************
   // zero-wait slave: read data and error are set up in the setup
   // phase so that they are ready in the access phase
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && !err_reg;
   assign mapped = (paddr == STATUS_OFS) || (paddr == FS_ADJ_OFS) ||
                   (paddr == INT_STATUS_OFS) || (paddr == INT_MASK_OFS);

   // status word shows the block's own state
   always_comb begin
      status_word = '0;
      status_word[ST_TRIM_BIT] = trim_link.busy;
      status_word[ST_OOR_BIT] = oor_reg;
      status_word[ST_EXT_BIT] = extended_control_enable;
      status_word[ST_PD_BIT] = trim_link.powered;
      status_word[ST_FS_LSB +: 8] = fs_reg;
   end

   // ********************************************************
   // read path and error
   // ********************************************************
   always_comb begin
      rdata_next = rdata_reg;
      err_next = err_reg;
      if (setup) begin
         err_next = !mapped;
         rdata_next = '0;
         if (!pwrite) begin
            case (paddr)
               STATUS_OFS: rdata_next = status_word;
               FS_ADJ_OFS: rdata_next = {24'h000000, fs_adj_reg};
               INT_STATUS_OFS: rdata_next = {29'h0, ist_reg};
               INT_MASK_OFS: rdata_next = {29'h0, imask_reg};
               default: rdata_next = '0;
            endcase
         end
      end
   end

   // ********************************************************
   // writable registers
   // ********************************************************
   always_comb begin
      fs_adj_next = fs_adj_reg;
      imask_next = imask_reg;
      if (wr_en && paddr == FS_ADJ_OFS) begin
         fs_adj_next = pwdata[7:0];
      end
      if (wr_en && paddr == INT_MASK_OFS) begin
         imask_next = pwdata[EV_W-1:0];
      end
   end

   // ********************************************************
   // events and sticky status
   // ********************************************************
   always_comb begin
      ev_set = '0;
      ev_set[EV_DONE_BIT] = trim_link.done;
      ev_set[EV_OOR_BIT] = oor_reg && !oor_q_reg;
      ev_set[EV_IGN_BIT] = trim_link.ignored;
      ist_next = ist_reg;
      if (wr_en && paddr == INT_STATUS_OFS) begin
         ist_next = ist_reg & ~pwdata[EV_W-1:0];
      end
      // a new event beats a clear in the same cycle
      ist_next = ist_next | ev_set;
   end

   // ********************************************************
   // full-scale selection
   // ********************************************************
   // frozen while trimming: the host must leave mode and scale pins
   // alone then, and holding the value keeps a stray change harmless
   always_comb begin
      fs_next = fs_reg;
      if (trim_link.busy) begin
         fs_next = fs_reg;
      end else if (extended_control_enable) begin
         fs_next = fs_adj_reg;
      end else if (full_scale_select) begin
         fs_next = FS_NORMAL;
      end else begin
         fs_next = FS_REDUCED;
      end
   end

   // ********************************************************
   // out-of-range flag
   // ********************************************************
   always_comb begin
      oor_next = range_link.oor;
      oor_q_next = oor_reg;
   end

   // ********************************************************
   // register bank
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_adj_reg <= FS_ADJ_RST;
         fs_reg <= FS_NORMAL;
         ist_reg <= '0;
         imask_reg <= INT_MASK_RST;
         oor_reg <= 1'b0;
         oor_q_reg <= 1'b0;
         rdata_reg <= '0;
         err_reg <= 1'b0;
      end else begin
         fs_adj_reg <= fs_adj_next;
         fs_reg <= fs_next;
         ist_reg <= ist_next;
         imask_reg <= imask_next;
         oor_reg <= oor_next;
         oor_q_reg <= oor_q_next;
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   assign pready = 1'b1;
   assign prdata = rdata_reg;
   assign pslverr = psel && penable && err_reg;
   // differential pair: high leg and low leg while clipped
   assign out_of_range_p = oor_reg;
   assign out_of_range_n = !oor_reg;
   // host watches this fall before trusting data
   assign self_trim_active = trim_link.busy;
   assign powered_down = trim_link.powered;
   assign full_scale_code = fs_reg;
   assign irq = |(ist_reg & imask_reg);

endmodule // conv_ctrl

`default_nettype wire

// ===== rtl/conv_ctrl_if.sv
/*
 * internal carriers between the top and its two helpers.
 * assumes all three sit on the same pclk.
 */
`timescale 1ns/100ps
`default_nettype none

// ********************************************************
// trim sequencer link
// ********************************************************
interface trim_link_if;
   logic busy;        // trim in progress
   logic done;        // one-cycle pulse at trim end
   logic ignored;     // one-cycle pulse: request seen while powered down
   logic powered;     // device is powered down
   modport seq (output busy, output done, output ignored, output powered);
   modport top (input busy, input done, input ignored, input powered);
endinterface

// ********************************************************
// range monitor link
// ********************************************************
interface range_link_if;
   logic oor;         // any bus clipped this sample
   modport mon (output oor);
   modport top (input oor);
endinterface

`default_nettype wire

// ===== rtl/conv_ctrl_pkg.sv
/*
 * constants shared by the converter control block: register map,
 * reset values, field positions and calibration timing.
 * assumes a 100 MHz pclk; the power-up and trim counts derive from that period.
 */
package conv_ctrl_pkg;

   // ********************************************************
   // clock and timing
   // ********************************************************
   localparam int CLK_PERIOD_NS = 10;           // pclk period
   localparam int PWRUP_DELAY_NS = 2000;         // settle before power-on trim
   localparam int PWRUP_DELAY_CYC = (PWRUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIM_LEN_NS = 1400;            // length of one trim run
   localparam int TRIM_LEN_CYC = (TRIM_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQ_LOW_CYC = 8;               // least low time of request
   localparam int REQ_HIGH_CYC = 8;              // request must stay high one cycle more than this
   localparam int CNT_W = 16;                    // width of timing counters

   // ********************************************************
   // register map (byte addresses)
   // ********************************************************
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] FS_ADJ_OFS = 8'h04;
   localparam logic [7:0] INT_STATUS_OFS = 8'h08;
   localparam logic [7:0] INT_MASK_OFS = 8'h0c;

   // ********************************************************
   // field positions and reset values
   // ********************************************************
   localparam int ST_TRIM_BIT = 0;               // status: trim running
   localparam int ST_OOR_BIT = 1;                // status: out of range
   localparam int ST_EXT_BIT = 2;                // status: extended mode
   localparam int ST_PD_BIT = 3;                 // status: powered down
   localparam int ST_FS_LSB = 8;                 // status: applied full scale
   localparam int EV_DONE_BIT = 0;               // event: trim finished
   localparam int EV_OOR_BIT = 1;                // event: out of range began
   localparam int EV_IGN_BIT = 2;                // event: request ignored
   localparam int EV_W = 3;
   localparam logic [7:0] FS_ADJ_RST = 8'h80;
   localparam logic [EV_W-1:0] INT_MASK_RST = 3'h0;
   localparam logic [7:0] FS_NORMAL = 8'hff;     // full amplitude code
   localparam logic [7:0] FS_REDUCED = 8'hc0;    // three quarters amplitude
   localparam logic [7:0] CODE_MIN = 8'h00;
   localparam logic [7:0] CODE_MAX = 8'hff;
   localparam logic [7:0] CODE_MID_LO = 8'h7f;
   localparam logic [7:0] CODE_MID_HI = 8'h80;

   // ********************************************************
   // trim sequencer states
   // ********************************************************
   typedef enum logic [2:0] {
      TS_START, TS_SETTLE, TS_IDLE, TS_ARMED, TS_RUN
   } trim_state_e;

endpackage

// ===== rtl/range_monitor.sv
/*
 * per-bus code former: turns the true differential result into an
 * offset-binary code, clips it and flags clipping.
 * assumes samples arrive with a one-cycle valid strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module range_monitor
   import conv_ctrl_pkg::*;
#(
   parameter int BUSES = 2,
   parameter int IN_W = 10
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // samples, signed lsb steps from mid-scale
   input wire logic sample_valid,
   input wire logic [BUSES*IN_W-1:0] sample_diff,
   // codes out
   output logic [BUSES*8-1:0] code_out,
   range_link_if.mon link
);

   logic [BUSES-1:0] clip_reg, clip_next;

   genvar g;
   generate
      for (g = 0; g < BUSES; g++) begin : g_bus
         logic signed [IN_W-1:0] diff;
         logic signed [IN_W+1:0] true_code;   // may fall outside 0..255
         logic [7:0] code_reg, code_next;
         logic dith_reg, dith_next;            // mid-scale alternation
         logic clip_nx;                        // this bus clips, one writer per bit
         assign diff = sample_diff[g*IN_W +: IN_W];
         assign clip_next[g] = clip_nx;

         // ********************************************************
         // code forming and clipping
         // ********************************************************
         always_comb begin
            code_next = code_reg;
            dith_next = dith_reg;
            clip_nx = clip_reg[g];
            if (diff > 0) begin
               true_code = (IN_W+2)'(diff) + (IN_W+2)'(CODE_MID_HI);
            end else begin
               true_code = (IN_W+2)'(diff) + (IN_W+2)'(CODE_MID_LO);
            end
            if (sample_valid) begin
               if (diff == 0) begin
                  // equal inputs wander between the two mid codes
                  code_next = dith_reg ? CODE_MID_HI : CODE_MID_LO;
                  dith_next = !dith_reg;
                  clip_nx = 1'b0;
               end else if (true_code < 0) begin
                  code_next = CODE_MIN;
                  clip_nx = 1'b1;
               end else if (true_code > (IN_W+2)'(CODE_MAX)) begin
                  code_next = CODE_MAX;
                  clip_nx = 1'b1;
               end else begin
                  code_next = true_code[7:0];
                  clip_nx = 1'b0;
               end
            end
         end

         // code and dither registers
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               code_reg <= CODE_MID_LO;
               dith_reg <= 1'b0;
            end else begin
               code_reg <= code_next;
               dith_reg <= dith_next;
            end
         end
         assign code_out[g*8 +: 8] = code_reg;
      end
   endgenerate

   // clip flags held until the next sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clip_reg <= '0;
      end else begin
         clip_reg <= clip_next;
      end
   end

   // either or both buses clipped
   assign link.oor = |clip_reg;

endmodule // range_monitor

`default_nettype wire

// ===== rtl/trim_sequencer.sv
/*
 * self-trim sequencer: power-on trim after a settle delay and
 * on-command trim from a filtered request pin.
 * assumes request and power-down pins are synchronous to pclk.
 */
`timescale 1ns/100ps
`default_nettype none

module trim_sequencer
   import conv_ctrl_pkg::*;
#(
   parameter int PWRUP_CYC = PWRUP_DELAY_CYC,
   parameter int TRIM_CYC = TRIM_LEN_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins
   input wire logic trim_request,
   input wire logic power_down_pin,
   // to top
   trim_link_if.seq link
);

   trim_state_e state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;     // settle / high / run counter
   logic [CNT_W-1:0] low_reg, low_next;     // saturating low-time count
   logic req_q_reg, req_q_next;             // request one cycle ago
   logic done_reg, done_next;
   logic ign_reg, ign_next;

   // ********************************************************
   // next-state logic
   // ********************************************************
   // only clock edges are counted, so a clock that starts late merely
   // shifts the whole sequence in time and leaves it unchanged
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      req_q_next = trim_request;
      done_next = 1'b0;
      ign_next = 1'b0;
      // low time counts only while awake; asleep the filter restarts
      if (trim_request || power_down_pin) begin
         low_next = '0;
      end else if (low_reg < CNT_W'(REQ_LOW_CYC)) begin
         low_next = low_reg + 1'b1;
      end else begin
         low_next = low_reg;
      end
      case (state_reg)
         TS_START: begin
            // pin caught at the first edge after release
            if (trim_request) begin
               state_next = TS_IDLE;
            end else begin
               state_next = TS_SETTLE;
               cnt_next = '0;
            end
         end
         TS_SETTLE: begin
            // delay counter frozen while held in power down
            if (!power_down_pin) begin
               if (cnt_reg >= CNT_W'(PWRUP_CYC - 1)) begin
                  state_next = TS_RUN;
                  cnt_next = '0;
               end else begin
                  cnt_next = cnt_reg + 1'b1;
               end
            end
         end
         TS_IDLE: begin
            if (trim_request && !req_q_reg && power_down_pin) begin
               ign_next = 1'b1;
            end else if (trim_request && !req_q_reg &&
                         low_reg >= CNT_W'(REQ_LOW_CYC)) begin
               state_next = TS_ARMED;
               cnt_next = CNT_W'(1);
            end
         end
         TS_ARMED: begin
            // a short pulse or sleep abandons the request
            if (!trim_request || power_down_pin) begin
               state_next = TS_IDLE;
               ign_next = power_down_pin;
            end else if (cnt_reg >= CNT_W'(REQ_HIGH_CYC)) begin
               state_next = TS_RUN;
               cnt_next = '0;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         TS_RUN: begin
            // power down cannot cut a run short
            if (cnt_reg >= CNT_W'(TRIM_CYC - 1)) begin
               state_next = TS_IDLE;
               done_next = 1'b1;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         default: begin
            state_next = TS_IDLE;
         end
      endcase
   end

   // ********************************************************
   // state registers
   // ********************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= TS_START;
         cnt_reg <= '0;
         low_reg <= '0;
         req_q_reg <= 1'b0;
         done_reg <= 1'b0;
         ign_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         low_reg <= low_next;
         req_q_reg <= req_q_next;
         done_reg <= done_next;
         ign_reg <= ign_next;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   assign link.busy = (state_reg == TS_RUN);
   assign link.done = done_reg;
   assign link.ignored = ign_reg;
   // sleep is deferred until the run completes
   assign link.powered = power_down_pin && (state_reg != TS_RUN);

endmodule // trim_sequencer

`default_nettype wire

// ===== testbench/conv_ctrl_checker.sv
/* assertions on conv_ctrl ports.
   assumes one pclk domain; bound at the foot. */
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_checker
   import conv_ctrl_pkg::*;
#(
   parameter int TRIM_CYC = TRIM_LEN_CYC,
   parameter int IN_W = 10
) (
   // clock and inputs
   input wire logic pclk,
   input wire logic presetn,
   input wire logic trim_request,
   input wire logic sample_valid,
   input wire logic [2*IN_W-1:0] sample_diff,
   // outputs
   input wire logic out_of_range_p,
   input wire logic out_of_range_n,
   input wire logic self_trim_active,
   input wire logic powered_down
);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***
   // helpers
   // ***
   logic [7:0] run_reg; // cycles of the run so far
   logic signed [IN_W-1:0] da; // bus a step
   logic signed [IN_W-1:0] db; // bus b step
   logic clip; // a bus would leave 00..ff
   // counter, as a run is too long for a repetition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= 8'h00;
      end else begin
         run_reg <= self_trim_active ? run_reg + 8'h01 : 8'h00;
      end
   end
   assign da = sample_diff[IN_W-1:0];
   assign db = sample_diff[2*IN_W-1:IN_W];
   assign clip = da > 127 || da < -127 || db > 127 || db < -127;
   // ***
   // assertions
   // ***
   a_oor_legs: assert property (out_of_range_p != out_of_range_n)
      else $error("oor legs equal");
   a_oor_set: assert property (sample_valid && clip |-> ##2 out_of_range_p)
      else $error("oor missed");
   a_oor_clear: assert property (sample_valid && !clip |-> ##2 !out_of_range_p)
      else $error("oor stuck");
   a_run_len: assert property ($fell(self_trim_active) |-> run_reg == TRIM_CYC)
      else $error("run length");
   a_run_gap: assert property ($fell(self_trim_active) |=> !self_trim_active [*8])
      else $error("run relaunched");
   a_short_req: assert property (
      $fell(trim_request) && !self_trim_active |=> !self_trim_active)
      else $error("short request ran");
   a_pd_defer: assert property (self_trim_active |-> !powered_down)
      else $error("slept in run");
   a_asleep_req: assert property (
      powered_down && $rose(trim_request) |=> !self_trim_active [*8])
      else $error("asleep request ran");
   c_run: cover property ($fell(self_trim_active));
   c_clip: cover property (sample_valid && clip);
   c_asleep: cover property (powered_down && $rose(trim_request));
endmodule // conv_ctrl_checker
bind conv_ctrl conv_ctrl_checker #(.TRIM_CYC(TRIM_CYC), .IN_W(IN_W)) u_chk (.pclk, .presetn,
   .trim_request, .sample_valid, .sample_diff, .out_of_range_p, .out_of_range_n,
   .self_trim_active, .powered_down);
`default_nettype wire

// ===== testbench/conv_ctrl_tb.sv
/* bench for conv_ctrl: apb tasks, host model, samples.
   assumes the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, x, g) begin n_checks++; if ((g) !== (x)) begin n_errors++; \
   $display("wrong value %s exp %h got %h", n, x, g); end end
module conv_ctrl_tb
   import conv_ctrl_pkg::*;
;
   localparam int PW = 4; // short settle
   localparam int TR = 6; // short run
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic sample_valid = 1'b0;
   logic [19:0] sample_diff = 20'h0;
   logic pready, pslverr, irq, e, self_trim_active, powered_down, out_of_range_p;
   logic trim_request, power_down_pin, full_scale_select, extended_control_enable;
   logic [15:0] code_out;
   logic [7:0] full_scale_code;
   int n_errors = 0, n_checks = 0, n_trim = 0, n0 = 0;
   conv_ctrl #(.PWRUP_CYC(PW), .TRIM_CYC(TR)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .full_scale_select, .extended_control_enable,
      .trim_request, .power_down_pin, .sample_valid, .sample_diff, .code_out, .out_of_range_p,
      .out_of_range_n(), .self_trim_active, .powered_down, .full_scale_code, .irq);
   host_model HOST (.pclk, .self_trim_active, .trim_request, .power_down_pin,
      .full_scale_select, .extended_control_enable);
   always #5 pclk = ~pclk; // 100 MHz
   // run cycles seen so far
   always @(posedge pclk) begin
      if (self_trim_active === 1'b1) n_trim <= n_trim + 1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer, held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK("prdata", x, q)
      `CHK("pslverr", a > 8'h0c, e)
   endtask
   // one sample; code a cycle on, flag a cycle later
   task automatic smp(input logic [9:0] a, b, input logic [15:0] x, input logic o);
      sample_valid <= 1'b1;
      sample_diff <= {b, a};
      @(posedge pclk);
      sample_valid <= 1'b0;
      @(posedge pclk);
      `CHK("code_out", x, code_out)
      @(posedge pclk);
      `CHK("out_of_range_p", o, out_of_range_p)
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      tick(10);
      presetn <= 1'b1;
      tick(8);
      `CHK("powered_down", 1'b1, powered_down)
      HOST.pins(1'b1, 1'b0, 1'b0);
      tick(PW + TR + 4);
      `CHK("power-on run", TR, n_trim)
      rd(INT_STATUS_OFS, 32'h1);
      rd(INT_MASK_OFS, 32'h0);
      apb(1'b1, INT_MASK_OFS, 32'h1);
      tick(1);
      `CHK("irq", 1'b1, irq)
      apb(1'b1, INT_STATUS_OFS, 32'h1);
      tick(1);
      `CHK("irq", 1'b0, irq)
      rd(FS_ADJ_OFS, 32'h80);
      apb(1'b1, FS_ADJ_OFS, 32'h33);
      apb(1'b1, 8'h10, 32'h55);
      rd(8'h10, 32'h0);
      rd(STATUS_OFS, 32'hff00);
      HOST.pins(1'b0, 1'b0, 1'b0);
      tick(2);
      `CHK("full_scale_code", FS_REDUCED, full_scale_code)
      HOST.pins(1'b0, 1'b1, 1'b0);
      tick(2);
      `CHK("full_scale_code", 8'h33, full_scale_code)
      HOST.pins(1'b1, 1'b0, 1'b0);
      n0 = n_trim;
      HOST.cal(7);
      tick(12);
      `CHK("short request", n0, n_trim)
      HOST.cal(9);
      tick(TR + 2);
      `CHK("command run", n0 + TR, n_trim)
      HOST.cal(9);
      HOST.power_down_pin <= 1'b1;
      tick(1);
      `CHK("powered_down", 1'b0, powered_down)
      tick(TR);
      `CHK("powered_down", 1'b1, powered_down)
      n0 = n_trim;
      HOST.cal(9);
      tick(12);
      `CHK("asleep request", n0, n_trim)
      rd(INT_STATUS_OFS, 32'h5);
      HOST.pins(1'b1, 1'b0, 1'b0);
      smp(10'sd200, 10'sd0, 16'h7fff, 1'b1);
      smp(10'sd0, 10'sd0, 16'h807f, 1'b0);
      smp(-10'sd200, 10'sd5, 16'h8500, 1'b1);
      smp(-10'sd127, 10'sd127, 16'hff00, 1'b0);
      rd(INT_STATUS_OFS, 32'h7);
      HOST.trim_request <= 1'b1;
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      n0 = n_trim;
      tick(PW + TR + 12);
      `CHK("skipped power-on run", n0, n_trim)
      end_of_test;
   end
   // watchdog far beyond the few hundred cycles needed
   initial begin
      tick(5000);
      n_errors++;
      end_of_test;
   end
endmodule // conv_ctrl_tb
`default_nettype wire

// ===== testbench/host_model.sv
/* host pin model driving the control pins.
   assumes tasks are called just after a pclk edge. */
`timescale 1ns/100ps
`default_nettype none
module host_model
   import conv_ctrl_pkg::*;
(
   // clock and watched status
   input wire logic pclk,
   input wire logic self_trim_active,
   // driven pins
   output logic trim_request,
   output logic power_down_pin,
   output logic full_scale_select,
   output logic extended_control_enable
);
   // powered down at power-up, so settle waits
   initial begin
      trim_request = 1'b0;
      power_down_pin = 1'b1;
      full_scale_select = 1'b1;
      extended_control_enable = 1'b0;
   end
   // low for the minimum, then high for hi cycles
   task automatic cal(input int hi);
      repeat (REQ_LOW_CYC) @(posedge pclk);
      trim_request <= 1'b1;
      repeat (hi) @(posedge pclk);
      trim_request <= 1'b0;
   endtask
   // pins move only after the run ends; clock never stops
   task automatic pins(input logic fs, input logic ext, input logic pd);
      while (self_trim_active) @(posedge pclk);
      full_scale_select <= fs;
      extended_control_enable <= ext;
      power_down_pin <= pd;
      @(posedge pclk);
   endtask
endmodule // host_model
`default_nettype wire
